/* File: design/tmc_edge_sync.sv */
module tmc_edge_sync #(
	parameter bit PRESENT = 1'b1
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	logic stage_one;
	logic stage_two;
	logic stage_three;

	// ********************************************************
	// Two-flop synchroniser followed by an edge detector.
	// ********************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stage_one <= 1'b0;
			stage_two <= 1'b0;
			stage_three <= 1'b0;
		end else begin
			stage_one <= pin;
			stage_two <= stage_one;
			stage_three <= stage_two;
		end
	end

	assign rise = PRESENT & stage_two & ~stage_three;
	assign fall = PRESENT & ~stage_two & stage_three;

endmodule

/* File: design/tmc_pkg.sv */
package tmc_pkg;

	// ********************************************************
	// Register byte addresses.
	// ********************************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_COMPARE = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE_ZERO = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE_ONE = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h18;

	// ********************************************************
	// Field positions and reset values.
	// ********************************************************
	localparam int DATA_W = 32;
	localparam int RUN_BIT = 0;
	localparam int CLOCK_SELECT_LSB = 0;
	localparam int CLEAR_ENABLE_BIT = 2;
	localparam int CAPTURE_TIMING_LSB = 3;
	localparam int SOFT_TRIGGER_BIT = 5;
	localparam int WRITE_ZERO_BIT = 6;
	localparam logic RUN_RESET = 1'h0;
	localparam logic [1:0] CLOCK_SELECT_RESET = 2'h0;
	localparam logic CLEAR_ENABLE_RESET = 1'h0;
	localparam logic [1:0] CAPTURE_TIMING_RESET = 2'h0;
	localparam logic WRITE_ZERO_RESET = 1'h0;
	localparam logic SOFT_TRIGGER_READ = 1'h1;

	// ********************************************************
	// Clock select and capture timing codes.
	// ********************************************************
	localparam logic [1:0] CLK_PIN = 2'h0;
	localparam logic [1:0] CLK_DIV_A = 2'h1;
	localparam logic [1:0] CLK_DIV_B = 2'h2;
	localparam logic [1:0] CLK_DIV_C = 2'h3;
	localparam logic [1:0] CAPTURE_OFF = 2'h0;
	localparam logic [1:0] CAPTURE_PINS = 2'h1;
	localparam logic [1:0] CAPTURE_PIN_EDGES = 2'h2;
	localparam logic [1:0] CAPTURE_MATCH = 2'h3;

	// ********************************************************
	// Prescaler taps and channel limits.
	// ********************************************************
	localparam int PRE_W = 5;
	localparam logic [PRE_W-1:0] PRE_DIV_A_MASK = 5'h01;
	localparam logic [PRE_W-1:0] PRE_DIV_B_MASK = 5'h07;
	localparam logic [PRE_W-1:0] PRE_DIV_C_MASK = 5'h1F;
	localparam int LAST_PIN_CHANNEL = 6;
	localparam int LAST_CHANNEL = 9;

	typedef enum logic [1:0] {
		TMC_BUS_IDLE,
		TMC_BUS_WAIT,
		TMC_BUS_DONE
	} tmc_bus_t;

endpackage

/* File: design/tmc_timer_mode.sv */
// What this block does
// RULE1: Two-bit field selects pin or prescaler clock.
// RULE2: Clear enable low never clears on match.
// RULE3: Clear enable high clears counter on match.
// RULE4: Capture timing code 00 disables hardware captures.
// RULE5: Code 01: input0 rise, input1 rise.
// RULE6: Code 10: input0 rise, input0 fall.
// RULE7: Code 11: other channel match edges. The code ignores match edges on channels seven to nine, which have no pins.
// RULE8: Writing zero to bit five captures count.
// RULE9: Bit five reads one, resets one.
// RULE10: Pins exist only on channels zero to six.
// RULE11: Software writes bit six zero; rest zero.
// RULE12: Pin edges synchronised and detected before use.
module tmc_timer_mode #(
	parameter int CHANNEL = 0,
	parameter int COUNT_W = 16
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [tmc_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tmc_pkg::DATA_W-1:0] pwdata,
	output logic [tmc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_input_zero,
	input wire logic capture_input_one,
	input wire logic match_source,
	output logic count_match
);
	import tmc_pkg::*;

	localparam bit HAS_PINS = CHANNEL <= LAST_PIN_CHANNEL;

	if (CHANNEL < 0 || CHANNEL > LAST_CHANNEL) begin : bad_channel
		$error("Channel number out of range.");
	end
	if (COUNT_W < 2 || COUNT_W > DATA_W) begin : bad_width
		$error("Counter width not supported.");
	end

	tmc_bus_t bus_state;
	logic run;
	logic [1:0] count_clock_select;
	logic counter_clear_enable;
	logic [1:0] capture_timing_select;
	logic write_zero_bit;
	logic [COUNT_W-1:0] compare_reg_one;
	logic [COUNT_W-1:0] count;
	logic [COUNT_W-1:0] capture_reg_zero;
	logic [COUNT_W-1:0] capture_reg_one;
	logic [PRE_W-1:0] prescale;
	logic in_zero_rise;
	logic in_zero_fall;
	logic in_one_rise;
	logic match_q;
	logic match_rise;
	logic match_fall;
	logic tick;
	logic clear_hit;
	logic soft_capture;
	logic capture_zero_event;
	logic capture_one_event;
	logic access;
	logic write_mode;
	logic [DATA_W-1:0] next_prdata;
	logic [DATA_W-1:0] mode_word;

	function automatic logic prescale_tick(input logic [PRE_W-1:0] value,
		input logic [PRE_W-1:0] mask);
		prescale_tick = (value & mask) == mask;
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
		case (addr)
			ADDR_CONTROL, ADDR_COMPARE, ADDR_MODE: addr_mapped = 1'b1;
			ADDR_CAPTURE_ZERO, ADDR_CAPTURE_ONE, ADDR_COUNT: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [DATA_W-1:0] widen(input logic [COUNT_W-1:0] value);
		widen = '0;
		widen[COUNT_W-1:0] = value;
	endfunction

	// ********************************************************
	// Pin synchronisers and match edge detection.
	// ********************************************************
	tmc_edge_sync #(.PRESENT(HAS_PINS)) sync_zero (
		.clock(clock),
		.nrst(nrst),
		.pin(capture_input_zero),
		.rise(in_zero_rise),
		.fall(in_zero_fall)
	); // [RULE12] [RULE10]

	tmc_edge_sync #(.PRESENT(HAS_PINS)) sync_one (
		.clock(clock),
		.nrst(nrst),
		.pin(capture_input_one),
		.rise(in_one_rise),
		.fall()
	); // [RULE12] [RULE10]

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match_source;
		end
	end

	assign match_rise = HAS_PINS & match_source & ~match_q; // [RULE7]
	assign match_fall = HAS_PINS & ~match_source & match_q; // [RULE7]

	// ********************************************************
	// APB slave with one wait state.
	// ********************************************************
	assign access = psel & penable & pready;
	assign write_mode = access & pwrite & (paddr == ADDR_MODE);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bus_state <= TMC_BUS_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			case (bus_state)
				TMC_BUS_IDLE: begin
					if (psel && penable) begin
						bus_state <= TMC_BUS_WAIT;
						pready <= 1'b1;
						pslverr <= ~addr_mapped(paddr);
					end
				end
				TMC_BUS_WAIT: begin
					bus_state <= TMC_BUS_DONE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				TMC_BUS_DONE: begin
					bus_state <= TMC_BUS_IDLE;
				end
				default: begin
					bus_state <= TMC_BUS_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		mode_word = '0;
		mode_word[CLOCK_SELECT_LSB+:2] = count_clock_select;
		mode_word[CLEAR_ENABLE_BIT] = counter_clear_enable;
		mode_word[CAPTURE_TIMING_LSB+:2] = capture_timing_select;
		mode_word[SOFT_TRIGGER_BIT] = SOFT_TRIGGER_READ; // [RULE9]
		mode_word[WRITE_ZERO_BIT] = write_zero_bit;
	end

	always_comb begin
		next_prdata = '0;
		case (paddr)
			ADDR_CONTROL: next_prdata[RUN_BIT] = run;
			ADDR_COMPARE: next_prdata = widen(compare_reg_one);
			ADDR_MODE: next_prdata = mode_word;
			ADDR_CAPTURE_ZERO: next_prdata = widen(capture_reg_zero);
			ADDR_CAPTURE_ONE: next_prdata = widen(capture_reg_one);
			ADDR_COUNT: next_prdata = widen(count);
			default: next_prdata = '0;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prdata <= '0;
		end else if (bus_state == TMC_BUS_IDLE && psel && penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// ********************************************************
	// Software registers.
	// ********************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			run <= RUN_RESET;
			compare_reg_one <= '0;
		end else if (access && pwrite && !pslverr) begin
			if (paddr == ADDR_CONTROL) begin
				run <= pwdata[RUN_BIT];
			end
			if (paddr == ADDR_COMPARE) begin
				compare_reg_one <= pwdata[COUNT_W-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_clock_select <= CLOCK_SELECT_RESET;
			counter_clear_enable <= CLEAR_ENABLE_RESET;
			capture_timing_select <= CAPTURE_TIMING_RESET;
			write_zero_bit <= WRITE_ZERO_RESET;
		end else if (write_mode) begin
			count_clock_select <= pwdata[CLOCK_SELECT_LSB+:2];
			counter_clear_enable <= pwdata[CLEAR_ENABLE_BIT];
			capture_timing_select <= pwdata[CAPTURE_TIMING_LSB+:2];
			write_zero_bit <= pwdata[WRITE_ZERO_BIT];
		end
	end

	// ********************************************************
	// Prescaler and count clock selection.
	// ********************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prescale <= '0;
		end else if (run) begin
			prescale <= prescale + 1'b1;
		end else begin
			prescale <= '0;
		end
	end

	always_comb begin
		case (count_clock_select) // [RULE1]
			CLK_PIN: tick = in_zero_rise;
			CLK_DIV_A: tick = prescale_tick(prescale, PRE_DIV_A_MASK);
			CLK_DIV_B: tick = prescale_tick(prescale, PRE_DIV_B_MASK);
			CLK_DIV_C: tick = prescale_tick(prescale, PRE_DIV_C_MASK);
			default: tick = 1'b0;
		endcase
	end

	// ********************************************************
	// Up-counter with optional clear on compare match.
	// ********************************************************
	assign clear_hit = counter_clear_enable && (count == compare_reg_one); // [RULE2] [RULE3]

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
		end else if (!run) begin
			count <= '0;
		end else if (tick) begin
			if (clear_hit) begin
				count <= '0; // [RULE3]
			end else begin
				count <= count + 1'b1; // [RULE2]
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_match <= 1'b0;
		end else begin
			count_match <= run && (count == compare_reg_one);
		end
	end

	// ********************************************************
	// Capture registers.
	// ********************************************************
	assign soft_capture = write_mode && !pwdata[SOFT_TRIGGER_BIT]; // [RULE8]

	always_comb begin
		capture_zero_event = soft_capture;
		capture_one_event = 1'b0;
		case (capture_timing_select)
			CAPTURE_OFF: begin
				capture_one_event = 1'b0; // [RULE4]
			end
			CAPTURE_PINS: begin
				capture_zero_event = soft_capture | in_zero_rise; // [RULE5]
				capture_one_event = in_one_rise; // [RULE5]
			end
			CAPTURE_PIN_EDGES: begin
				capture_zero_event = soft_capture | in_zero_rise; // [RULE6]
				capture_one_event = in_zero_fall; // [RULE6]
			end
			CAPTURE_MATCH: begin
				capture_zero_event = soft_capture | match_rise; // [RULE7]
				capture_one_event = match_fall; // [RULE7]
			end
			default: begin
				capture_one_event = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			capture_reg_zero <= '0;
		end else if (capture_zero_event) begin
			capture_reg_zero <= count;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			capture_reg_one <= '0;
		end else if (capture_one_event) begin
			capture_reg_one <= count;
		end
	end

	// ********************************************************
	// Assertions and cover properties.
	// ********************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	count_step_a: assert property (run && tick && !clear_hit |=> // [RULE1]
		count == $past(count) + 1'b1)
		else $error("Counter did not step on selected tick.");
	div_c_rate_a: assert property (run && count_clock_select == CLK_DIV_C
		&& $stable(count_clock_select) && tick |=> !tick [*8]) // [RULE1]
		else $error("Slowest prescale tick came too soon.");
	no_clear_a: assert property (run && tick && !counter_clear_enable // [RULE2]
		&& count != '1 |=> count != '0)
		else $error("Counter cleared with clear disabled.");
	clear_match_a: assert property (run && tick && counter_clear_enable // [RULE3]
		&& count == compare_reg_one |=> count == '0)
		else $error("Counter not cleared on compare match.");
	capture_off_a: assert property (capture_timing_select == CAPTURE_OFF // [RULE4]
		&& !soft_capture |=> $stable(capture_reg_zero) && $stable(capture_reg_one))
		else $error("Capture happened while disabled.");
	pins_rise_a: assert property (capture_timing_select == CAPTURE_PINS // [RULE5]
		&& in_one_rise |=> capture_reg_one == $past(count))
		else $error("Input one rise did not capture.");
	pin_fall_a: assert property (capture_timing_select == CAPTURE_PIN_EDGES // [RULE6]
		&& in_zero_fall |=> capture_reg_one == $past(count))
		else $error("Input zero fall did not capture.");
	match_edge_a: assert property (capture_timing_select == CAPTURE_MATCH // [RULE7]
		&& HAS_PINS && match_source && !match_q |=> capture_reg_zero == $past(count))
		else $error("Match rise did not capture.");
	soft_capture_a: assert property (write_mode && !pwdata[SOFT_TRIGGER_BIT] // [RULE8]
		|=> capture_reg_zero == $past(count))
		else $error("Software capture missed.");
	trigger_read_a: assert property (access && !pwrite && paddr == ADDR_MODE // [RULE9]
		|-> prdata[SOFT_TRIGGER_BIT])
		else $error("Soft trigger bit read as zero.");
	no_pins_a: assert property (!HAS_PINS && capture_timing_select != CAPTURE_OFF // [RULE10]
		|=> $stable(capture_reg_one))
		else $error("Capture on channel without pins.");
	sync_delay_a: assert property (in_zero_rise |-> // [RULE12]
		$past(capture_input_zero, 2) && !$past(capture_input_zero, 3))
		else $error("Pin edge not passed through synchroniser.");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("Ready held longer than one cycle.");

	clear_cover: cover property (run && tick && clear_hit);
	pin_capture_cover: cover property (capture_one_event
		&& capture_timing_select == CAPTURE_PIN_EDGES);
	match_capture_cover: cover property (capture_zero_event && match_rise);
	soft_capture_cover: cover property (soft_capture);

endmodule

/* File: verif/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import tmc_pkg::*;

	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic pin_zero;
	logic pin_one;
	logic match_line;
	logic match_flag;
	logic far = 1'b0;
	logic [DATA_W-1:0] far_prdata;
	logic far_pready;
	logic far_pslverr;
	int num_errors = 0;
	int checks = 0;
	int ratio[3] = '{2, 8, 32};

	always #50 clock = ~clock;

	tmc_timer_mode #(.CHANNEL(0), .COUNT_W(16)) dut (
		.clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel & !far), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_input_zero(pin_zero), .capture_input_one(pin_one),
		.match_source(match_line), .count_match(match_flag)
	);

	// A channel without capture pins shares the bus and the pins.
	tmc_timer_mode #(.CHANNEL(7), .COUNT_W(16)) dut_far (
		.clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel & far), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(far_prdata), .pready(far_pready),
		.pslverr(far_pslverr), .capture_input_zero(pin_zero), .capture_input_one(pin_one),
		.match_source(match_line), .count_match()
	);

	tmc_pin_model pins (
		.clock(clock), .capture_input_zero(pin_zero), .capture_input_one(pin_one),
		.match_source(match_line)
	);

	// ********************************************************
	// Closing report, comparisons and bus cycles.
	// ********************************************************
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_range(input string name, input int lo, input int hi,
		input logic [31:0] got);
		checks++;
		if (!(got >= lo && got <= hi) || $isunknown(got)) begin
			num_errors++;
			$display("wrong value %s expected %0d to %0d seen %h", name, lo, hi, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while ((far ? far_pready : pready) !== 1'b1 && n < 20);
		rd = far ? far_prdata : prdata;
		err = far ? far_pslverr : pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			summarize();
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string name);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h0, rd, err);
		chk(name, exp, rd);
	endtask

	// ********************************************************
	// Main sequence.
	// ********************************************************
	initial begin
		logic [31:0] rd;
		logic err;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		rd_chk(ADDR_MODE, 32'h20, "mode reset");
		wr(ADDR_MODE, 32'hFFFF_FFA3);
		rd_chk(ADDR_MODE, 32'h23, "mode fields a");
		wr(ADDR_MODE, 32'hFFFF_FFBC);
		rd_chk(ADDR_MODE, 32'h3C, "mode fields b");
		apb(1'b0, 8'h40, 32'h0, rd, err);
		chk("unmapped data", 32'h0, rd);
		chk("unmapped error", 32'h1, {31'h0, err});
		wr(ADDR_MODE, 32'h20);
		wr(ADDR_CONTROL, 32'h1);
		pins.pulse(0, 5);
		rd_chk(ADDR_COUNT, 32'h5, "pin clocked count");
		wr(ADDR_MODE, 32'h00);
		rd_chk(ADDR_CAPTURE_ZERO, 32'h5, "soft capture");
		pins.pulse(0, 2);
		wr(ADDR_MODE, 32'h20);
		rd_chk(ADDR_CAPTURE_ZERO, 32'h5, "soft write one");
		pins.pulse(1, 1);
		pins.pulse(2, 1);
		rd_chk(ADDR_CAPTURE_ONE, 32'h0, "captures off");
		rd_chk(ADDR_CAPTURE_ZERO, 32'h5, "captures off zero");
		wr(ADDR_MODE, 32'h28);
		pins.pulse(1, 1);
		rd_chk(ADDR_CAPTURE_ONE, 32'h7, "input one rise");
		wr(ADDR_MODE, 32'h30);
		pins.pulse(1, 1);
		rd_chk(ADDR_CAPTURE_ONE, 32'h7, "input one unused");
		pins.pulse(0, 1);
		rd_chk(ADDR_CAPTURE_ONE, 32'h8, "input zero fall");
		wr(ADDR_MODE, 32'h38);
		pins.pulse(0, 1);
		rd_chk(ADDR_CAPTURE_ONE, 32'h8, "pins ignored");
		pins.pulse(2, 1);
		rd_chk(ADDR_CAPTURE_ZERO, 32'h9, "match rise");
		rd_chk(ADDR_CAPTURE_ONE, 32'h9, "match fall");
		wr(ADDR_CONTROL, 32'h0);
		wr(ADDR_COMPARE, 32'h3);
		wr(ADDR_MODE, 32'h24);
		wr(ADDR_CONTROL, 32'h1);
		pins.pulse(0, 3);
		chk("count match", 32'h1, {31'h0, match_flag});
		pins.pulse(0, 2);
		rd_chk(ADDR_COUNT, 32'h1, "clear on match");
		chk("count match off", 32'h0, {31'h0, match_flag});
		for (int c = 1; c < 4; c++) begin
			wr(ADDR_CONTROL, 32'h0);
			wr(ADDR_MODE, 32'h20 | c);
			wr(ADDR_CONTROL, 32'h1);
			repeat (128) @(posedge clock);
			apb(1'b0, ADDR_COUNT, 32'h0, rd, err);
			chk_range("prescaled count", 128 / ratio[c-1] - 1, 128 / ratio[c-1] + 3, rd);
		end
		far <= 1'b1;
		wr(ADDR_MODE, 32'h20);
		wr(ADDR_CONTROL, 32'h1);
		pins.pulse(0, 2);
		rd_chk(ADDR_COUNT, 32'h0, "far pin clock");
		wr(ADDR_MODE, 32'h29);
		pins.pulse(0, 1);
		pins.pulse(1, 1);
		wr(ADDR_MODE, 32'h39);
		pins.pulse(2, 1);
		rd_chk(ADDR_CAPTURE_ZERO, 32'h0, "far capture zero");
		rd_chk(ADDR_CAPTURE_ONE, 32'h0, "far capture one");
		summarize();
	end
endmodule

/* File: verif/tmc_pin_model.sv */
module tmc_pin_model (
	input wire logic clock,
	output logic capture_input_zero,
	output logic capture_input_one,
	output logic match_source
);
	timeunit 1ns;
	timeprecision 100ps;

	// ********************************************************
	// Capture pins and the source channel match line.
	// ********************************************************
	initial begin
		capture_input_zero = 1'b0;
		capture_input_one = 1'b0;
		match_source = 1'b0;
	end

	task automatic drive(input int which, input logic lvl);
		@(posedge clock);
		case (which)
			0: capture_input_zero <= lvl;
			1: capture_input_one <= lvl;
			default: match_source <= lvl;
		endcase
	endtask

	// Each level is held several clocks so the synchroniser sees every edge.
	task automatic pulse(input int which, input int n);
		for (int i = 0; i < n; i++) begin
			drive(which, 1'b1);
			repeat (3) @(posedge clock);
			drive(which, 1'b0);
			repeat (3) @(posedge clock);
		end
	endtask
endmodule
